// ==== pkg/dfth_pkg.sv ====
package dfth_pkg;

  // Bus and register map (word indices, byte address is four times the index)
  localparam int DFTH_DATA_W = 32;
  localparam logic [7:0] DFTH_IDX_THRSEL = 8'hFB;
  localparam logic [7:0] DFTH_IDX_CTRL = 8'hFC;
  localparam logic [7:0] DFTH_IDX_STAT = 8'hFD;
  localparam logic [7:0] DFTH_IDX_IRQSTAT = 8'hFE;
  localparam logic [7:0] DFTH_IDX_IRQMASK = 8'hFF;

  // Threshold select fields
  localparam int DFTH_WR_CODE_LSB = 4;
  localparam int DFTH_RD_CODE_LSB = 0;
  localparam int DFTH_CODE_W = 3;
  localparam logic [7:0] DFTH_THRSEL_RST = 8'h00;
  localparam logic [7:0] DFTH_THRSEL_MASK = 8'h77;

  // Control fields
  localparam int DFTH_CTRL_EN_BIT = 0;
  localparam int DFTH_CTRL_DIR_BIT = 1;
  localparam int DFTH_CTRL_CACHE_BIT = 2;
  localparam logic [2:0] DFTH_CTRL_RST = 3'h0;

  // Status fields
  localparam int DFTH_STAT_MET_BIT = 0;
  localparam int DFTH_STAT_ACT_BIT = 1;
  localparam int DFTH_STAT_DIR_BIT = 2;
  localparam int DFTH_STAT_LVL_LSB = 16;

  // Interrupt fields
  localparam int DFTH_IRQ_W = 3;
  localparam int DFTH_IRQ_MET_BIT = 0;
  localparam int DFTH_IRQ_START_BIT = 1;
  localparam int DFTH_IRQ_STOP_BIT = 2;
  localparam logic [2:0] DFTH_IRQ_RST = 3'h0;

  // FIFO geometry in bytes
  localparam int DFTH_LVL_W = 10;
  localparam logic [9:0] DFTH_FIFO_BYTES = 10'h200;
  localparam logic [9:0] DFTH_EMPTY = 10'h000;

  // Start amount in bytes for codes 000 through 111
  localparam logic [9:0] DFTH_THR_TABLE [8] = '{
    10'h020, 10'h080, 10'h100, 10'h140, 10'h180, 10'h1B0, 10'h1D0, 10'h1E0
  };

  // Transfer direction
  localparam logic DFTH_DIR_WR = 1'b1;

  // Burst state
  typedef enum logic [1:0] {
    DFTH_IDLE = 2'b00,
    DFTH_WR_BURST = 2'b01,
    DFTH_RD_BURST = 2'b10
  } dfth_state_t;

endpackage

// ==== core/dfth_thresh_cmp.sv ====
`timescale 1ns/10ps
module dfth_thresh_cmp (
  // Selection
  input wire logic [dfth_pkg::DFTH_CODE_W-1:0] thrCode,
  input wire logic cacheEn,
  // Amount in bytes, data or free space
  input wire logic [dfth_pkg::DFTH_LVL_W-1:0] amount,
  // Result
  output logic thrMet
);
  import dfth_pkg::*;

  // Byte figure of the chosen code
  wire logic [DFTH_LVL_W-1:0] thrBytes;
  assign thrBytes = DFTH_THR_TABLE[thrCode];

  // Cache mode uses the same figures here
  wire logic unusedCache;
  assign unusedCache = cacheEn;

  // Condition holds once the amount reaches the figure
  assign thrMet = (amount >= thrBytes);
endmodule

// ==== core/dfth_top.sv ====
// Summary of operation
// - Status flag follows the selected threshold condition, registered one clock later.
// - Write code in bits 6-4 governs FIFO-to-memory bursts; cache enable has no effect.
// - Read code in bits 2-0 governs memory-to-FIFO bursts; cache enable has no effect.
// - Write burst starts at 32..480 data bytes per code, stops when empty.
// - Read burst starts at 32..480 free bytes per code, stops when full.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module dfth_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [dfth_pkg::DFTH_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [dfth_pkg::DFTH_DATA_W-1:0] hrdata,
  // Data FIFO occupancy in bytes
  input wire logic [dfth_pkg::DFTH_LVL_W-1:0] fifoLevel,
  // DMA channel
  output logic dmaBurstActive,
  output logic dmaBurstDirWr,
  output logic thresholdMetFlag,
  // Interrupt
  output logic irq
);
  import dfth_pkg::*;

  // Registers
  logic [7:0] thrSel_q;
  logic [2:0] ctrl_q;
  logic [DFTH_IRQ_W-1:0] irqStat_q;
  logic [DFTH_IRQ_W-1:0] irqStat_d;
  logic [DFTH_IRQ_W-1:0] irqMask_q;
  dfth_state_t state_q;
  dfth_state_t state_d;
  logic met_q;
  logic irq_q;
  logic active_q;
  logic dirWrOut_q;
  // Bus pipeline
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] addrIdx_q;
  logic hreadyout_q;
  logic [DFTH_DATA_W-1:0] hrdata_q;

  // Bus address phase decode
  wire logic busAccept;
  wire logic [7:0] reqIdx;
  wire logic addrInMap;
  assign busAccept = hsel & htrans[1] & hready;
  assign reqIdx = haddr[9:2];
  assign addrInMap = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

  // Data phase write strobes
  wire logic wrThrSel;
  wire logic wrCtrl;
  wire logic wrIrqStat;
  wire logic wrIrqMask;
  assign wrThrSel = wrPend_q && (addrIdx_q == DFTH_IDX_THRSEL);
  assign wrCtrl = wrPend_q && (addrIdx_q == DFTH_IDX_CTRL);
  assign wrIrqStat = wrPend_q && (addrIdx_q == DFTH_IDX_IRQSTAT);
  assign wrIrqMask = wrPend_q && (addrIdx_q == DFTH_IDX_IRQMASK);

  // Mask after this cycle, so irq follows a mask write on the same edge
  wire logic [DFTH_IRQ_W-1:0] irqMaskNext;
  assign irqMaskNext = wrIrqMask ? hwdata[DFTH_IRQ_W-1:0] : irqMask_q;

  // Control fields
  wire logic dmaEnable;
  wire logic dirWr;
  wire logic cacheLineThresholdEnable;
  wire logic [DFTH_CODE_W-1:0] writeDirThresholdCode;
  wire logic [DFTH_CODE_W-1:0] readDirThresholdCode;
  assign dmaEnable = ctrl_q[DFTH_CTRL_EN_BIT];
  assign dirWr = ctrl_q[DFTH_CTRL_DIR_BIT];
  assign cacheLineThresholdEnable = ctrl_q[DFTH_CTRL_CACHE_BIT];
  assign writeDirThresholdCode = thrSel_q[DFTH_WR_CODE_LSB +: DFTH_CODE_W];
  assign readDirThresholdCode = thrSel_q[DFTH_RD_CODE_LSB +: DFTH_CODE_W];

  // Free space and fill markers
  wire logic [DFTH_LVL_W-1:0] fifoSpace;
  wire logic fifoEmpty;
  wire logic fifoFull;
  assign fifoSpace = DFTH_FIFO_BYTES - fifoLevel;
  assign fifoEmpty = (fifoLevel == DFTH_EMPTY);
  assign fifoFull = (fifoLevel >= DFTH_FIFO_BYTES);

  // Threshold comparators, data for write and space for read
  wire logic wrMet;
  wire logic rdMet;
  dfth_thresh_cmp uWrCmp (
    .thrCode(writeDirThresholdCode),
    .cacheEn(cacheLineThresholdEnable),
    .amount(fifoLevel),
    .thrMet(wrMet)
  );
  dfth_thresh_cmp uRdCmp (
    .thrCode(readDirThresholdCode),
    .cacheEn(cacheLineThresholdEnable),
    .amount(fifoSpace),
    .thrMet(rdMet)
  );

  // Condition of the selected direction, fresh every clock
  wire logic metNow;
  assign metNow = (dirWr == DFTH_DIR_WR) ? wrMet : rdMet;

  // Burst next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      DFTH_IDLE: begin
        if (dmaEnable && (dirWr == DFTH_DIR_WR) && wrMet) begin
          state_d = DFTH_WR_BURST;
        end else if (dmaEnable && (dirWr != DFTH_DIR_WR) && rdMet) begin
          state_d = DFTH_RD_BURST;
        end
      end
      DFTH_WR_BURST: begin
        if (fifoEmpty || !dmaEnable) begin
          state_d = DFTH_IDLE;
        end
      end
      DFTH_RD_BURST: begin
        if (fifoFull || !dmaEnable) begin
          state_d = DFTH_IDLE;
        end
      end
      default: begin
        state_d = DFTH_IDLE;
      end
    endcase
  end

  // Burst events
  wire logic burstStart;
  wire logic burstStop;
  wire logic metRise;
  assign burstStart = (state_q == DFTH_IDLE) && (state_d != DFTH_IDLE);
  assign burstStop = (state_q != DFTH_IDLE) && (state_d == DFTH_IDLE);
  assign metRise = metNow && !met_q;

  // Sticky status, a set beats a write-one clear
  wire logic [DFTH_IRQ_W-1:0] irqSet;
  assign irqSet = {burstStop, burstStart, metRise};
  always_comb begin
    irqStat_d = irqStat_q;
    if (wrIrqStat) begin
      irqStat_d = irqStat_q & ~hwdata[DFTH_IRQ_W-1:0];
    end
    irqStat_d = irqStat_d | irqSet;
  end

  // Burst state and threshold flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= DFTH_IDLE;
      met_q <= 1'b0;
      active_q <= 1'b0;
      dirWrOut_q <= 1'b0;
    end else begin
      state_q <= state_d;
      met_q <= metNow;
      active_q <= (state_d != DFTH_IDLE);
      dirWrOut_q <= (state_d == DFTH_WR_BURST);
    end
  end

  // Software registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thrSel_q <= DFTH_THRSEL_RST;
      ctrl_q <= DFTH_CTRL_RST;
      irqMask_q <= DFTH_IRQ_RST;
      irqStat_q <= DFTH_IRQ_RST;
    end else begin
      if (wrThrSel) thrSel_q <= hwdata[7:0] & DFTH_THRSEL_MASK;
      if (wrCtrl) ctrl_q <= hwdata[2:0];
      irqMask_q <= irqMaskNext;
      irqStat_q <= irqStat_d;
    end
  end

  // Interrupt output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat_d & irqMaskNext);
    end
  end

  // Read data selection
  wire logic [DFTH_DATA_W-1:0] statWord;
  wire logic [DFTH_DATA_W-1:0] rdMux;
  assign statWord = {6'h00, fifoLevel, 13'h0000,
                     dirWr, (state_q != DFTH_IDLE), met_q};
  assign rdMux = (addrIdx_q == DFTH_IDX_THRSEL) ? {24'h000000, thrSel_q} :
                 (addrIdx_q == DFTH_IDX_CTRL) ? {29'h00000000, ctrl_q} :
                 (addrIdx_q == DFTH_IDX_STAT) ? statWord :
                 (addrIdx_q == DFTH_IDX_IRQSTAT) ? {29'h00000000, irqStat_q} :
                 (addrIdx_q == DFTH_IDX_IRQMASK) ? {29'h00000000, irqMask_q} :
                 32'h00000000;

  // AHB-Lite pipeline: writes zero wait, reads one wait state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addrIdx_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else begin
      if (rdPend_q) begin
        hrdata_q <= rdMux;
        hreadyout_q <= 1'b1;
        rdPend_q <= 1'b0;
        wrPend_q <= 1'b0;
      end else begin
        wrPend_q <= busAccept && hwrite && addrInMap;
        rdPend_q <= busAccept && !hwrite;
        hreadyout_q <= !(busAccept && !hwrite);
        if (busAccept) addrIdx_q <= addrInMap ? reqIdx : 8'h00;
      end
    end
  end

  // Outputs from flops, hresp tied low
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign dmaBurstActive = active_q;
  assign dmaBurstDirWr = dirWrOut_q;
  assign thresholdMetFlag = met_q;
  assign irq = irq_q;

  wire logic [2:0] unusedSize;
  assign unusedSize = hsize;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence sIdleWrMet;
    (state_q == DFTH_IDLE) && dmaEnable && dirWr && wrMet;
  endsequence
  sequence sIdleRdMet;
    (state_q == DFTH_IDLE) && dmaEnable && !dirWr && rdMet;
  endsequence
  // Running bursts that have not yet reached their stop point
  sequence sWrRunning;
    (state_q == DFTH_WR_BURST) && !fifoEmpty && dmaEnable;
  endsequence
  sequence sRdRunning;
    (state_q == DFTH_RD_BURST) && !fifoFull && dmaEnable;
  endsequence

  AST_FLAG_FOLLOWS: assert property (!rst && metNow |=> thresholdMetFlag)
    else $error("flag not raised after condition held");
  AST_FLAG_DROPS: assert property (!rst && !metNow |=> !thresholdMetFlag)
    else $error("flag stayed high without condition");
  AST_WR_START: assert property (sIdleWrMet |=> dmaBurstActive && dmaBurstDirWr)
    else $error("write burst did not start");
  AST_RD_START: assert property (sIdleRdMet |=> dmaBurstActive && !dmaBurstDirWr)
    else $error("read burst did not start");
  AST_WR_FIG: assert property (
      (state_q == DFTH_IDLE) && dmaEnable && dirWr && fifoLevel < DFTH_THR_TABLE[writeDirThresholdCode]
      |=> !dmaBurstActive)
    else $error("write burst started below figure");
  AST_WR_STOP: assert property ((state_q == DFTH_WR_BURST) && fifoEmpty |=> !dmaBurstActive)
    else $error("write burst ran past empty");
  AST_RD_STOP: assert property ((state_q == DFTH_RD_BURST) && fifoFull |=> !dmaBurstActive)
    else $error("read burst ran past full");
  AST_RD_FIG: assert property (
      (state_q == DFTH_IDLE) && dmaEnable && !dirWr && fifoSpace < DFTH_THR_TABLE[readDirThresholdCode]
      |=> !dmaBurstActive)
    else $error("read burst started below figure");
  AST_LEVEL_TRACK: assert property ($changed(fifoLevel) && !dirWr && !$changed(thrSel_q)
      |=> thresholdMetFlag == $past(rdMet))
    else $error("flag lags occupancy");
  AST_WR_HOLD: assert property (sWrRunning |=> dmaBurstActive && dmaBurstDirWr)
    else $error("write burst ended before empty");
  AST_RD_HOLD: assert property (sRdRunning |=> dmaBurstActive && !dmaBurstDirWr)
    else $error("read burst ended before full");
  AST_NO_ENABLE: assert property ((state_q == DFTH_IDLE) && !dmaEnable |=> !dmaBurstActive)
    else $error("burst started while disabled");
  // Flag against the raw figures, independent of the comparator outputs
  AST_WR_FLAG_FIG: assert property (
      !rst && dirWr && (fifoLevel >= DFTH_THR_TABLE[writeDirThresholdCode])
      |=> thresholdMetFlag)
    else $error("flag low with write figure reached");
  AST_RD_FLAG_FIG: assert property (
      !rst && !dirWr && ((DFTH_FIFO_BYTES - fifoLevel) < DFTH_THR_TABLE[readDirThresholdCode])
      |=> !thresholdMetFlag)
    else $error("flag high with read figure not reached");
endmodule

// ==== tb/dfth_mem_model.sv ====
`timescale 1ns/10ps
module dfth_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // DMA channel from the device
  input wire logic dmaBurstActive,
  input wire logic dmaBurstDirWr,
  // Bench preset and memory wait
  input wire logic loadEn,
  input wire logic [9:0] loadLevel,
  input wire logic stall,
  // Data FIFO occupancy
  output logic [9:0] fifoLevel
);
  // One 32-byte line per beat unless memory waits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fifoLevel <= 10'h000;
    end else if (loadEn) begin
      fifoLevel <= loadLevel;
    end else if (dmaBurstActive && !stall) begin
      if (dmaBurstDirWr) begin
        fifoLevel <= (fifoLevel > 10'h020) ? fifoLevel - 10'h020 : 10'h000;
      end else begin
        fifoLevel <= (fifoLevel < 10'h1E0) ? fifoLevel + 10'h020 : 10'h200;
      end
    end
  end
endmodule

// ==== tb/dfth_top_tb.sv ====
`timescale 1ns/10ps
module dfth_top_tb;
  import dfth_pkg::*;
  logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, loadEn, stall;
  logic dmaBurstActive, dmaBurstDirWr, thresholdMetFlag, irq, m;
  logic [1:0] htrans;
  logic [2:0] hsize, c;
  logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
  logic [9:0] fifoLevel, loadLevel, thr, lv;
  int errCount, totalChecks;
  localparam logic [31:0] A_SEL = 32'h3EC, A_CTRL = 32'h3F0, A_STAT = 32'h3F4;
  localparam logic [31:0] A_IST = 32'h3F8, A_MSK = 32'h3FC;
  localparam logic [9:0] THR [8] = '{10'h020, 10'h080, 10'h100, 10'h140, 10'h180, 10'h1B0, 10'h1D0, 10'h1E0};

  dfth_top dfth_top_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .fifoLevel(fifoLevel), .dmaBurstActive(dmaBurstActive),
    .dmaBurstDirWr(dmaBurstDirWr), .thresholdMetFlag(thresholdMetFlag), .irq(irq));
  dfth_mem_model dfth_mem_model_i (.ref_clk(ref_clk), .rst(rst), .dmaBurstActive(dmaBurstActive),
    .dmaBurstDirWr(dmaBurstDirWr), .loadEn(loadEn), .loadLevel(loadLevel), .stall(stall),
    .fifoLevel(fifoLevel));

  // Clock source
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected threshold condition
  function automatic logic metExp(input logic dirWr, input logic [2:0] cd, input logic [9:0] l);
    return dirWr ? (l >= THR[cd]) : ((10'h200 - l) >= THR[cd]);
  endfunction

  task end_of_test;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait for the answer or give up
  task waitSig(input logic v, input logic onBus, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      lfsr = lfsrNext(lfsr);
      stall <= lfsr[0];
      n++;
    end while (((onBus ? hreadyout : dmaBurstActive) !== v) && n < lim);
    if ((onBus ? hreadyout : dmaBurstActive) !== v) begin
      errCount++;
      end_of_test();
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitSig(1'b1, 1'b1, 50);
    htrans <= 2'h0;
    hwdata <= wd;
    waitSig(1'b1, 1'b1, 50);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask

  task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task setLevel(input logic [9:0] v);
    loadEn <= 1'b1;
    loadLevel <= v;
    @(posedge ref_clk);
    loadEn <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // Main sequence
  initial begin
    {hsel, hwrite, loadEn, stall, htrans, haddr, hwdata, loadLevel} = '0;
    hsize = 3'h2;
    lfsr = 32'hB2B0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    hsel <= 1'b1;
    @(posedge ref_clk);
    rdc("sel rst", A_SEL, 32'h0);
    rdc("ctrl rst", A_CTRL, 32'h0);
    rdc("stat rst", A_STAT, 32'h1);
    rdc("irq stat", A_IST, 32'h1);
    chk("irq masked", 1'b0, irq);
    bus(1'b1, A_MSK, 32'h1);
    @(posedge ref_clk);
    chk("irq on", 1'b1, irq);
    bus(1'b1, A_IST, 32'h7);
    bus(1'b1, A_MSK, 32'h0);
    @(posedge ref_clk);
    chk("irq clear", 1'b0, irq);
    bus(1'b1, A_SEL, 32'hFFFF_FFFF);
    rdc("sel rsvd", A_SEL, 32'h77);
    bus(1'b1, 32'h3E8, 32'hFFFF_FFFF);
    rdc("unmapped", 32'h3E8, 32'h0);
    // Threshold sweep, both directions, boundary and random levels
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 8; k++) begin
        c = 3'(k);
        bus(1'b1, A_CTRL, (32'(d) << 1) | (32'(k % 2) << 2));
        rdc("ctrl", A_CTRL, (32'(d) << 1) | (32'(k % 2) << 2));
        bus(1'b1, A_SEL, d ? {c, 4'(7 - k)} : {3'(7 - k), 1'b0, c});
        thr = THR[c];
        for (int j = 0; j < 3; j++) begin
          lfsr = lfsrNext(lfsr);
          lv = (lfsr[9:0] > 10'h200) ? 10'h200 : lfsr[9:0];
          if (j < 2) lv = d ? thr - 10'(1 - j) : 10'h200 - thr + 10'(1 - j);
          setLevel(lv);
          m = metExp(d[0], c, lv);
          chk("met", m, thresholdMetFlag);
        end
        rdc("stat", A_STAT, (32'(lv) << 16) | (32'(d) << 2) | 32'(m));
      end
    end
    chk("irq masked", 1'b0, irq);
    // Write then read burst with memory stalling
    for (int d = 1; d >= 0; d--) begin
      bus(1'b1, A_IST, 32'h7);
      bus(1'b1, A_MSK, 32'h6);
      lfsr = lfsrNext(lfsr);
      c = lfsr[2:0];
      thr = THR[c];
      bus(1'b1, A_SEL, {c, 1'b0, c});
      setLevel(d ? thr - 10'h001 : 10'h201 - thr);
      bus(1'b1, A_CTRL, 32'h1 | (32'(d) << 1));
      repeat (4) @(posedge ref_clk);
      chk("no start", 1'b0, dmaBurstActive);
      setLevel(d ? thr : 10'h200 - thr);
      chk("start", 1'b1, dmaBurstActive);
      chk("dir", d, dmaBurstDirWr);
      waitSig(1'b0, 1'b0, 400);
      chk("stop level", d ? 10'h000 : 10'h200, fifoLevel);
      repeat (2) @(posedge ref_clk);
      chk("irq", 1'b1, irq);
      rdc("irq stat", A_IST, 32'h7);
      bus(1'b1, A_MSK, 32'h0);
      @(posedge ref_clk);
      chk("irq masked", 1'b0, irq);
      bus(1'b1, A_IST, 32'h7);
      bus(1'b1, A_MSK, 32'h7);
      @(posedge ref_clk);
      chk("irq cleared", 1'b0, irq);
      bus(1'b1, A_CTRL, 32'h0);
    end
    end_of_test();
  end
endmodule
